// File: design/fp_state_masked_store.sv
// decode and execute of the float state low store and the masked float store
`timescale 1ns/1ps
`default_nettype none
module fp_state_masked_store (
  // clock and reset
  input  wire logic               CLK_SYS_I,
  input  wire logic               RESET_I,
  // instruction issue
  input  wire logic               INSTR_VALID_I,
  input  wire fpst_pkg::instr_s   INSTR_I,
  output logic                    INSTR_READY_O,
  output logic                    INSTR_DONE_O,
  // float state
  input  wire logic               STATUS_FLOAT_ENABLE_BIT_I,
  input  wire logic               PROC_FLOAT_ENABLE_BIT_I,
  input  wire logic               FLOAT_OPERATION_BUSY_I,
  input  wire logic [31:0]        FP_STATE_LOW_I,
  output logic                    FTT_CLEAR_O,
  // traps and watchpoint
  input  wire fpst_pkg::watch_s   WATCH_I,
  output logic                    TRAP_VALID_O,
  output fpst_pkg::trap_e         TRAP_CODE_O,
  // memory request
  output logic                    MEM_REQ_O,
  output fpst_pkg::mem_req_s      MEM_O,
  input  wire logic               MEM_ACK_I,
  // register bus
  input  wire logic [3:0]         S_AXI_AWADDR_I,
  input  wire logic               S_AXI_AWVALID_I,
  output logic                    S_AXI_AWREADY_O,
  input  wire logic [31:0]        S_AXI_WDATA_I,
  input  wire logic [3:0]         S_AXI_WSTRB_I,
  input  wire logic               S_AXI_WVALID_I,
  output logic                    S_AXI_WREADY_O,
  output logic [1:0]              S_AXI_BRESP_O,
  output logic                    S_AXI_BVALID_O,
  input  wire logic               S_AXI_BREADY_I,
  input  wire logic [3:0]         S_AXI_ARADDR_I,
  input  wire logic               S_AXI_ARVALID_I,
  output logic                    S_AXI_ARREADY_O,
  output logic [31:0]             S_AXI_RDATA_O,
  output logic [1:0]              S_AXI_RRESP_O,
  output logic                    S_AXI_RVALID_O,
  input  wire logic               S_AXI_RREADY_I
);
  import fpst_pkg::*;

  state_e      state_q;
  logic        ready_q, done_q, ftt_q, trap_q, mreq_q, is_state_q;
  trap_e       tcode_q;
  mem_req_s    mem_q;
  logic [3:0]  ctrl_q;
  logic [31:0] count_q;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;

  logic        take, ibit, d_state, d_low, d_part, d_little, fp_ok, illegal, w_hit;
  logic [4:0]  rd;
  logic [7:0]  asi, bm, wbytes, sbytes;
  logic [1:0]  lane;
  logic [63:0] offs, ea;
  mem_req_s    d_mem;
  trap_e       d_trap;

  assign take = INSTR_VALID_I && ready_q;

  always_comb begin
    rd       = INSTR_I.word[F_RD_LO +: 5];
    ibit     = INSTR_I.word[F_IMM_BIT];
    d_state  = INSTR_I.word[F_OP_LO +: 2] == OP_STATE_STORE
               && INSTR_I.word[F_OP3_LO +: 6] == OP3_STATE;
    d_low    = d_state && rd == RD_LOW;
    asi      = ibit ? INSTR_I.asi_reg : INSTR_I.word[F_ASI_LO +: 8];
    lane     = (asi[7:4] == ASI_PARTIAL_HI) ? asi[2:1] : LANE_NONE;
    d_part   = INSTR_I.word[F_OP_LO +: 2] == OP_MEM
               && INSTR_I.word[F_OP3_LO +: 6] == OP3_DBL_ALT && lane != LANE_NONE;
    d_little = asi[3];
    offs     = ibit ? {{51{INSTR_I.word[F_SIMM_HI]}}, INSTR_I.word[F_SIMM_HI:0]}
                    : INSTR_I.src2;
    ea       = d_part ? INSTR_I.src1 : INSTR_I.src1 + offs;
    fp_ok    = STATUS_FLOAT_ENABLE_BIT_I && PROC_FLOAT_ENABLE_BIT_I
               && ctrl_q[CTRL_FPU_BIT];
    // lane mask from the low bits of src2, upper bits ignored
    bm = '0;
    for (int k = 0; k < 8; k++) begin
      case (lane)
        LANE_BYTE: bm[k] = INSTR_I.src2[k];
        LANE_HALF: bm[k] = INSTR_I.src2[k/2];
        LANE_WORD: bm[k] = INSTR_I.src2[k/4];
        default:   bm[k] = 1'b0;
      endcase
    end
    d_mem              = '0;
    d_mem.addr         = {ea[63:3], 3'h0};
    d_mem.asi          = asi;
    d_mem.implicit_asi = d_state;
    if (d_part && d_little) begin
      d_mem.data = INSTR_I.fdata;
      d_mem.be   = bm;
    end else if (d_part) begin
      // big-endian codes: byte order and mask order both flip
      d_mem.data = {<<8{INSTR_I.fdata}};
      d_mem.be   = {<<{bm}};
    end else begin
      d_mem.be   = ea[2] ? 8'hf0 : 8'h0f;
    end
    // conservative options trade false watch hits for cheaper compare
    sbytes = ctrl_q[CTRL_WBM_BIT] ? d_mem.be : 8'hff;
    wbytes = ctrl_q[CTRL_WMSK_BIT] ? WATCH_I.mask : {8{|WATCH_I.mask}};
    w_hit  = WATCH_I.en && ea[63:3] == WATCH_I.va[63:3] && |(sbytes & wbytes);
    illegal = (d_state && rd > RD_FULL)
              || (d_low && !ibit && |INSTR_I.word[F_SIMM_HI:F_ASI_LO])
              || (d_part && ibit);
    if (!(d_low || d_part) && !illegal) d_trap = TRAP_NONE;
    else if (illegal)                   d_trap = TRAP_ILLEGAL;
    else if (!fp_ok)                    d_trap = TRAP_FP_OFF;
    else if (d_part && !ctrl_q[CTRL_HW_BIT]) d_trap = TRAP_SPACE;
    else if (ea[1:0] != 2'h0)           d_trap = TRAP_MISALIGN;
    else if (d_part && ea[2])           d_trap = TRAP_DBL_MISALIGN;
    else if (w_hit)                     d_trap = TRAP_WATCH;
    else                                d_trap = TRAP_NONE;
  end

  // sequencer; a trap leaves memory and state untouched
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_q    <= ST_IDLE;
      ready_q    <= 1'b1;
      done_q     <= 1'b0;
      ftt_q      <= 1'b0;
      trap_q     <= 1'b0;
      tcode_q    <= TRAP_NONE;
      mreq_q     <= 1'b0;
      is_state_q <= 1'b0;
      mem_q      <= '0;
    end else begin
      done_q <= 1'b0;
      ftt_q  <= 1'b0;
      trap_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            if (d_trap != TRAP_NONE || !(d_low || d_part)) begin
              done_q  <= 1'b1;
              trap_q  <= d_trap != TRAP_NONE;
              tcode_q <= d_trap;
            end else begin
              ready_q    <= 1'b0;
              mem_q      <= d_mem;
              is_state_q <= d_low;
              tcode_q    <= TRAP_NONE;
              if (d_low) begin
                state_q <= ST_DRAIN;
              end else begin
                mreq_q  <= 1'b1;
                state_q <= ST_MEM;
              end
            end
          end
        end
        ST_DRAIN: begin
          if (!FLOAT_OPERATION_BUSY_I) begin
            mem_q.data <= {2{FP_STATE_LOW_I[7:0], FP_STATE_LOW_I[15:8],
                             FP_STATE_LOW_I[23:16], FP_STATE_LOW_I[31:24]}};
            mreq_q     <= 1'b1;
            state_q    <= ST_MEM;
          end
        end
        ST_MEM: begin
          if (MEM_ACK_I) begin
            mreq_q  <= 1'b0;
            done_q  <= 1'b1;
            ftt_q   <= is_state_q;
            ready_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
          mreq_q  <= 1'b0;
        end
      endcase
    end
  end

  // register bus write side
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      ctrl_q    <= CTRL_RESET;
    end else begin
      if (S_AXI_AWVALID_I && awready_q) begin
        awaddr_q  <= S_AXI_AWADDR_I;
        awready_q <= 1'b0;
      end
      if (S_AXI_WVALID_I && wready_q) begin
        wdata_q  <= S_AXI_WDATA_I;
        wstrb_q  <= S_AXI_WSTRB_I;
        wready_q <= 1'b0;
      end
      if (!awready_q && !wready_q && !bvalid_q) begin
        bvalid_q <= 1'b1;
        bresp_q  <= RESP_OKAY;
        if (awaddr_q == ADDR_CTRL) begin
          if (wstrb_q[0]) ctrl_q <= wdata_q[3:0];
        end else if (awaddr_q != ADDR_STAT && awaddr_q != ADDR_COUNT) begin
          bresp_q <= RESP_DECERR;
        end
      end
      if (bvalid_q && S_AXI_BREADY_I) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // register bus read side and completed store count
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
      count_q   <= '0;
    end else begin
      if (state_q == ST_MEM && MEM_ACK_I) count_q <= count_q + 32'h1;
      if (S_AXI_ARVALID_I && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= RESP_OKAY;
        case (S_AXI_ARADDR_I)
          ADDR_CTRL:  rdata_q <= {28'h0, ctrl_q};
          ADDR_STAT:  rdata_q <= {27'h0, !ready_q, 1'b0, tcode_q};
          ADDR_COUNT: rdata_q <= count_q;
          default: begin
            rdata_q <= '0;
            rresp_q <= RESP_DECERR;
          end
        endcase
      end
      if (rvalid_q && S_AXI_RREADY_I) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign INSTR_READY_O   = ready_q;
  assign INSTR_DONE_O    = done_q;
  assign FTT_CLEAR_O     = ftt_q;
  assign TRAP_VALID_O    = trap_q;
  assign TRAP_CODE_O     = tcode_q;
  assign MEM_REQ_O       = mreq_q;
  assign MEM_O           = mem_q;
  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O  = wready_q;
  assign S_AXI_BVALID_O  = bvalid_q;
  assign S_AXI_BRESP_O   = bresp_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RVALID_O  = rvalid_q;
  assign S_AXI_RDATA_O   = rdata_q;
  assign S_AXI_RRESP_O   = rresp_q;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);

  chk_drain_wait: assert property (
    $rose(mreq_q) && is_state_q |-> !$past(FLOAT_OPERATION_BUSY_I))
    else $error("state store issued while float ops busy");
  chk_ftt_after_ack: assert property (
    ftt_q |-> $past(mreq_q) && $past(MEM_ACK_I) && $past(is_state_q))
    else $error("trap-type clear without completed state store");
  chk_ftt_no_trap: assert property (
    take && d_low && d_trap != TRAP_NONE |=> !ftt_q [*3])
    else $error("trap-type cleared by trapping store");
  chk_ea_form: assert property (
    take && d_low && d_trap == TRAP_NONE |=>
      mem_q.addr[63:3] == 61'(($past(INSTR_I.src1) + $past(offs)) >> 3))
    else $error("state store address wrong");
  chk_illegal_bits: assert property (
    take && d_low && !ibit && |INSTR_I.word[12:5] |=> trap_q && tcode_q == TRAP_ILLEGAL)
    else $error("reserved bits not trapped");
  chk_fp_off: assert property (
    take && (d_low || d_part) && !illegal && !fp_ok |=> tcode_q == TRAP_FP_OFF)
    else $error("float-off trap missing");
  chk_word_align: assert property (
    take && (d_low || d_part) && ea[1:0] != 2'h0 |=> trap_q)
    else $error("misaligned store not trapped");
  chk_top_lane: assert property (
    take && d_part && d_trap == TRAP_NONE && lane == LANE_WORD && d_little
      && INSTR_I.src2[1:0] == 2'h2 |=> mem_q.be == 8'hf0)
    else $error("word lane mask order wrong");
  chk_imm_masked: assert property (
    take && d_part && ibit |=> tcode_q == TRAP_ILLEGAL)
    else $error("masked store with immediate not illegal");
  chk_dbl_align: assert property (
    take && d_part && d_trap != TRAP_ILLEGAL && fp_ok && ctrl_q[CTRL_HW_BIT]
      && ea[2:0] == 3'h4 |=> tcode_q == TRAP_DBL_MISALIGN)
    else $error("double misalign trap missing");
  chk_no_side: assert property (
    trap_q |-> !mreq_q && !ftt_q && $stable(mem_q))
    else $error("trapping store had a side effect");
endmodule
`default_nettype wire

// File: design/fpst_pkg.sv
// constants, encodings and carrier types for the float state and masked store block
package fpst_pkg;
  // instruction field positions
  localparam int F_OP_LO   = 30;
  localparam int F_RD_LO   = 25;
  localparam int F_OP3_LO  = 19;
  localparam int F_IMM_BIT = 13;
  localparam int F_ASI_LO  = 5;
  localparam int F_SIMM_HI = 12;
  // opcode encodings
  localparam logic [1:0] OP_STATE_STORE = 2'h2;
  localparam logic [1:0] OP_MEM         = 2'h3;
  localparam logic [5:0] OP3_STATE      = 6'h25;
  localparam logic [5:0] OP3_DBL_ALT    = 6'h37;
  localparam logic [4:0] RD_LOW         = 5'h00;
  localparam logic [4:0] RD_FULL        = 5'h01;
  // partial store space identifiers: c0-c5, c8-cd
  localparam logic [3:0] ASI_PARTIAL_HI = 4'hc;
  localparam logic [1:0] LANE_BYTE      = 2'h0;
  localparam logic [1:0] LANE_HALF      = 2'h1;
  localparam logic [1:0] LANE_WORD      = 2'h2;
  localparam logic [1:0] LANE_NONE      = 2'h3;
  // register map
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_STAT     = 4'h4;
  localparam logic [3:0]  ADDR_COUNT    = 4'h8;
  localparam logic [3:0]  CTRL_RESET    = 4'h3;
  localparam int          CTRL_FPU_BIT  = 0;
  localparam int          CTRL_HW_BIT   = 1;
  localparam int          CTRL_WBM_BIT  = 2;
  localparam int          CTRL_WMSK_BIT = 3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  typedef enum logic [2:0] {
    TRAP_NONE         = 3'h0,
    TRAP_ILLEGAL      = 3'h1,
    TRAP_FP_OFF       = 3'h2,
    TRAP_SPACE        = 3'h3,
    TRAP_MISALIGN     = 3'h4,
    TRAP_DBL_MISALIGN = 3'h5,
    TRAP_WATCH        = 3'h6
  } trap_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_DRAIN = 3'h2,
    ST_MEM   = 3'h4
  } state_e;

  typedef struct packed {
    logic [31:0] word;
    logic [63:0] src1;
    logic [63:0] src2;
    logic [63:0] fdata;
    logic [7:0]  asi_reg;
  } instr_s;

  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic [7:0]  be;
    logic [7:0]  asi;
    logic        implicit_asi;
  } mem_req_s;

  typedef struct packed {
    logic        en;
    logic [63:0] va;
    logic [7:0]  mask;
  } watch_s;
endpackage

// File: sim/fp_state_and_masked_store_bench.sv
// self-checking bench for the float state store and masked store block
`timescale 1ns/1ps
`default_nettype none
module fp_state_and_masked_store_bench;
  import fpst_pkg::*;
  logic clk, rst, valid, sen, pen, busy, rdy, done, ftt, tvo, mreq, ack;
  logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [3:0] awa, ara, dly;
  logic [1:0] brs, rrs;
  logic [31:0] wd, rd, fsr;
  instr_s ins;
  trap_e tc;
  mem_req_s mo, ml;
  watch_s wch;
  logic [7:0] mcnt;
  int mismatches, checks_done;
  logic in_busy;
  localparam logic [63:0] FD = 64'h0123456789abcdef;

  fp_state_masked_store fp_state_masked_store_i (.CLK_SYS_I(clk), .RESET_I(rst),
    .INSTR_VALID_I(valid), .INSTR_I(ins), .INSTR_READY_O(rdy), .INSTR_DONE_O(done),
    .STATUS_FLOAT_ENABLE_BIT_I(sen), .PROC_FLOAT_ENABLE_BIT_I(pen),
    .FLOAT_OPERATION_BUSY_I(busy), .FP_STATE_LOW_I(fsr), .FTT_CLEAR_O(ftt),
    .WATCH_I(wch), .TRAP_VALID_O(tvo), .TRAP_CODE_O(tc), .MEM_REQ_O(mreq), .MEM_O(mo),
    .MEM_ACK_I(ack), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr),
    .S_AXI_BRESP_O(brs), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rrs),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr));
  mem_model mem_model_i (.clk_i(clk), .rst_i(rst), .req_i(mreq), .mem_i(mo), .ack_o(ack),
    .delay_i(dly), .last_o(ml), .count_o(mcnt));

  always #12.5 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      end_of_test();
    end
  endtask

  function automatic logic [63:0] bsw64(input logic [63:0] x);
    for (int j = 0; j < 8; j++) bsw64[8*j+:8] = x[8*(7-j)+:8];
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int j = 0; j < 8; j++) rev8[j] = x[7-j];
  endfunction

  function automatic instr_s mk(input logic [31:0] w, input logic [63:0] s1, s2);
    mk = '{word: w, src1: s1, src2: s2, fdata: FD, asi_reg: 8'hc0};
  endfunction

  // bus cycles: payload held until each channel's own ready edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv && n < 50);
    r = brs;
    br <= 1'b0;
    guard(n, 50);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && n < 50);
    d = rd;
    r = rrs;
    rr <= 1'b0;
    guard(n, 50);
  endtask

  task automatic run(input instr_s i, output trap_e c, output logic t, f, q);
    int n;
    n = 0; f = 0; q = 0;
    @(posedge clk);
    valid <= 1'b1; ins <= i;
    do begin @(posedge clk); n++; end while (!rdy && n < 50);
    valid <= 1'b0;
    guard(n, 50);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      f |= ftt;
      q |= mreq;
      if (busy && mreq) in_busy = 1'b1;
    end while (!done && n < 200);
    t = tvo;
    c = tc;
    guard(n, 200);
  endtask

  task automatic sc_state();
    trap_e c; logic t, f, q;
    busy <= 1'b1; in_busy = 1'b0;
    fork
      run(mk({2'h2, 5'h0, 6'h25, 5'h1, 1'b1, 13'h1ffc}, 64'h1000, 64'h0), c, t, f, q);
      begin repeat (8) @(posedge clk); busy <= 1'b0; end
    join
    chk(in_busy, 0);
    chk(ml.data, bsw64({fsr, fsr}));
    chk(ml.addr, 64'hff8);
    chk({ml.be, ml.implicit_asi}, {8'hf0, 1'b1});
    chk({t, f, q}, 3'b011);
    run(mk({2'h2, 5'h0, 6'h25, 5'h1, 1'b0, 13'h0002}, 64'h2000, 64'h10), c, t, f, q);
    chk({ml.addr, ml.be}, {64'h2010, 8'h0f});
  endtask

  task automatic sc_masked();
    trap_e c; logic t, f, q; logic [7:0] a, m; logic [63:0] s2;
    s2 = 64'hff5a;
    for (int k = 0; k < 14; k++) begin
      if (k != 6 && k != 7) begin
        a = 8'hc0 | k[7:0];
        dly <= k[3:0];
        for (int j = 0; j < 8; j++) m[j] = s2[j >> a[2:1]];
        run(mk({2'h3, 5'h2, 6'h37, 5'h1, 1'b0, a, 5'h2}, 64'h3008, s2), c, t, f, q);
        chk({t, q}, 2'b01);
        chk({ml.addr[55:0], ml.asi}, {56'h3008, a});
        chk(ml.data, a[3] ? FD : bsw64(FD));
        chk(ml.be, a[3] ? m : rev8(m));
      end
    end
    dly <= 4'h0;
  endtask

  task automatic sc_traps();
    trap_e c; logic t, f, q;
    logic [31:0] w [7]; logic [63:0] a [7]; trap_e e [7];
    w = '{{2'h2, 5'h0, 6'h25, 5'h1, 1'b0, 13'h0022}, {2'h2, 5'h2, 6'h25, 5'h1, 1'b1, 13'h0},
          {2'h2, 5'h0, 6'h25, 5'h1, 1'b1, 13'h0}, {2'h3, 5'h2, 6'h37, 5'h1, 1'b1, 13'h0},
          {2'h3, 5'h2, 6'h37, 5'h1, 1'b0, 13'h1802}, {2'h3, 5'h2, 6'h37, 5'h1, 1'b0, 13'h1802},
          {2'h2, 5'h1, 6'h25, 5'h1, 1'b1, 13'h0}};
    a = '{64'h2000, 64'h2000, 64'h2001, 64'h3000, 64'h3004, 64'h3002, 64'h2000};
    e = '{TRAP_ILLEGAL, TRAP_ILLEGAL, TRAP_MISALIGN, TRAP_ILLEGAL, TRAP_DBL_MISALIGN,
          TRAP_MISALIGN, TRAP_NONE};
    for (int k = 0; k < 7; k++) begin
      run(mk(w[k], a[k], 64'hff), c, t, f, q);
      chk(c, e[k]);
      chk({t, f, q}, {e[k] != TRAP_NONE, 2'b00});
    end
  endtask

  // conservative watch compare hit, precise watch compare both hit and miss
  task automatic sc_watch();
    trap_e c; logic t, f, q; logic [1:0] r;
    wch <= '{en: 1'b1, va: 64'h3008, mask: 8'h01};
    axi_wr(4'h0, 32'h3, r);
    chk(r, RESP_OKAY);
    run(mk({2'h3, 5'h2, 6'h37, 5'h1, 1'b0, 13'h1802}, 64'h3008, 64'h01), c, t, f, q);
    chk({c, t, q}, {TRAP_WATCH, 2'b10});
    axi_wr(4'h0, 32'hf, r);
    chk(r, RESP_OKAY);
    run(mk({2'h3, 5'h2, 6'h37, 5'h1, 1'b0, 13'h1802}, 64'h3008, 64'h01), c, t, f, q);
    chk({c, t, q}, {TRAP_NONE, 2'b01});
    run(mk({2'h3, 5'h2, 6'h37, 5'h1, 1'b0, 13'h1802}, 64'h3008, 64'h80), c, t, f, q);
    chk({c, t, q}, {TRAP_WATCH, 2'b10});
    wch <= '0;
  endtask

  task automatic sc_fpoff();
    trap_e c; logic t, f, q; logic [1:0] r;
    for (int k = 0; k < 3; k++) begin
      sen <= (k != 0); pen <= (k != 1);
      axi_wr(4'h0, (k == 2) ? 32'h2 : 32'h3, r);
      chk(r, RESP_OKAY);
      run(mk({2'h2, 5'h0, 6'h25, 5'h1, 1'b1, 13'h0}, 64'h1000, 64'h0), c, t, f, q);
      chk({c, f, q}, {TRAP_FP_OFF, 2'b00});
      run(mk({2'h3, 5'h2, 6'h37, 5'h1, 1'b0, 13'h1802}, 64'h3008, 64'hff), c, t, f, q);
      chk({c, q}, {TRAP_FP_OFF, 1'b0});
    end
    sen <= 1'b1; pen <= 1'b1;
    axi_wr(4'h0, 32'h1, r);
    chk(r, RESP_OKAY);
    run(mk({2'h3, 5'h2, 6'h37, 5'h1, 1'b0, 13'h1802}, 64'h3008, 64'hff), c, t, f, q);
    chk({c, q}, {TRAP_SPACE, 1'b0});
  endtask

  // partial space codes are only ever issued with stores here
  initial begin
    logic [31:0] d; logic [1:0] r;
    clk = 0; rst = 1; valid = 0; ins = '0; sen = 1; pen = 1; busy = 0; dly = 0;
    fsr = 32'h89ab4c21; awa = 0; awv = 0; wd = 0; wv = 0; br = 0; ara = 0; arv = 0; rr = 0;
    mismatches = 0; checks_done = 0; wch = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    axi_rd(4'h0, d, r);
    chk({d, r}, {32'h3, RESP_OKAY});
    sc_state();
    sc_masked();
    sc_traps();
    sc_watch();
    sc_fpoff();
    axi_rd(4'hc, d, r);
    chk({d, r}, {32'h0, RESP_DECERR});
    axi_rd(4'h4, d, r);
    chk(d[4:0], {2'b00, TRAP_SPACE});
    axi_rd(4'h8, d, r);
    chk(d, {24'h0, mcnt});
    end_of_test();
  end
endmodule
`default_nettype wire

// File: sim/mem_model.sv
// memory side model that accepts store requests after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // store request side
  input  wire logic               req_i,
  input  wire fpst_pkg::mem_req_s mem_i,
  output logic                    ack_o,
  // bench view
  input  wire logic [3:0]         delay_i,
  output fpst_pkg::mem_req_s      last_o,
  output logic [7:0]              count_o
);
  import fpst_pkg::*;
  logic [3:0] wait_q;
  // ack lasts one edge only, so a released request never sees a stale ack
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_q <= '0;
      last_o <= '0;
      count_o <= '0;
    end else begin
      ack_o <= 1'b0;
      if (req_i && ack_o) begin
        last_o <= mem_i;
        count_o <= count_o + 8'h01;
        wait_q <= '0;
      end else if (req_i && wait_q == delay_i) begin
        ack_o <= 1'b1;
      end else if (req_i) begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire
